// file: pkg/pad_port_pkg.sv
/*
  constants for the general purpose pad port: pad count, mode codes,
  reset values and buzzer timing.
  assumes a single 25 MHz system clock.
*/
package pad_port_pkg;

  // ------------------------------------------------------------------
  // geometry and modes
  // ------------------------------------------------------------------
  localparam int          NUM_PADS     = 8;
  localparam int          PAD_FIVE     = 5;
  localparam int          PAD_SIX      = 6;
  localparam int          PAD_SEVEN    = 7;
  localparam logic [1:0]  MODE_INPUT   = 2'h0;
  localparam logic [1:0]  MODE_OUTPUT  = 2'h1;
  localparam logic [1:0]  MODE_ALT     = 2'h2;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [1:0]  MODE_RST     = 2'h0;
  localparam logic        LEVEL_RST    = 1'h0;

  // ------------------------------------------------------------------
  // buzzer timing
  // ------------------------------------------------------------------
  localparam int          CLK_HZ       = 25000000;
  localparam int          TONE_W       = 16;

endpackage

// file: verilog/general_purpose_pad_port.sv
/*
  general purpose pad port: each pad is input or output, pads five to seven also alternate.
  pads five, six and seven carry transmit monitor, alarm and buzzer.
  assumes pad inputs are asynchronous and are synchronised here.
*/
// Behaviour
// - pads select input, output or alternate function
// - input pad read returns synchronised pad level
// - output pad drives written level, readable back
// - alternate mode ignores user level writes
// - only pads five to seven accept alternate
// - pad five alternate shows transmit activity
// - pad six alternate shows alarm output
// - pad seven alternate drives buzzer wave
// - output pads drive push-pull both levels
// - alarm rises on fire, falls on clear
// - buzzer gives square wave at tone frequency
`timescale 1ns/1ps
module general_purpose_pad_port
  import pad_port_pkg::*;
#(
  parameter int N = NUM_PADS
)(
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // configuration and level writes
  input  wire logic                 cfg_we,
  input  wire logic [2:0]           cfg_pad,
  input  wire logic [1:0]           cfg_mode,
  input  wire logic                 lvl_we,
  input  wire logic [2:0]           lvl_pad,
  input  wire logic                 lvl_val,
  // internal functions
  input  wire logic                 radio_transmit_monitor,
  input  wire logic                 alarm_fire,
  input  wire logic                 alarm_clear,
  input  wire logic                 tone_on,
  input  wire logic [TONE_W-1:0]    tone_half,
  // pads
  input  wire logic [N-1:0]         pad_in,
  output logic      [N-1:0]         pad_out,
  output logic      [N-1:0]         pad_oe_n,
  // status
  output logic      [N-1:0]         rd_level,
  output logic      [2*N-1:0]       rd_mode
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [N-1:0]       sync1;
    logic [N-1:0]       sync2;
    logic [2*N-1:0]     mode;
    logic [N-1:0]       lvl;
    logic               alarm;
    logic               buzz;
    logic [TONE_W-1:0]  cnt;
    logic [N-1:0]       out;
    logic [N-1:0]       oe_n;
    logic [N-1:0]       rd;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  // alternate-capable pads
  function automatic logic has_alt(input int p);
    has_alt = (p == PAD_FIVE) || (p == PAD_SIX) || (p == PAD_SEVEN);
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic [1:0] m;
    logic       alt_lvl;
    m       = MODE_RST;
    alt_lvl = 1'b0;
    st_nxt  = st_r;
    // two flops before any logic sees a pad
    st_nxt.sync1 = pad_in;
    st_nxt.sync2 = st_r.sync1;
    if (cfg_we && (int'(cfg_pad) < N))
    begin
      if (cfg_mode == MODE_OUTPUT || cfg_mode == MODE_INPUT ||
          (cfg_mode == MODE_ALT && has_alt(int'(cfg_pad))))
        st_nxt.mode[2*cfg_pad +: 2] = cfg_mode;
    end
    // level writes stored only while in output mode
    if (lvl_we && (int'(lvl_pad) < N))
    begin
      if (st_r.mode[2*lvl_pad +: 2] == MODE_OUTPUT)
        st_nxt.lvl[lvl_pad] = lvl_val;
    end
    // fire wins over a clear in the same cycle
    if (alarm_fire)
      st_nxt.alarm = 1'b1;
    else if (alarm_clear)
      st_nxt.alarm = 1'b0;
    if (!tone_on || tone_half == '0)
    begin
      st_nxt.cnt  = '0;
      st_nxt.buzz = 1'b0;
    end
    else if (st_r.cnt >= tone_half - TONE_W'(1))
    begin
      st_nxt.cnt  = '0;
      st_nxt.buzz = ~st_r.buzz;
    end
    else
      st_nxt.cnt = st_r.cnt + TONE_W'(1);
    // pad drivers
    for (int p = 0; p < N; p++)
    begin
      m = st_r.mode[2*p +: 2];
      if (p == PAD_FIVE)
        alt_lvl = radio_transmit_monitor;
      else if (p == PAD_SIX)
        alt_lvl = st_r.alarm;
      else if (p == PAD_SEVEN)
        alt_lvl = st_r.buzz;
      else
        alt_lvl = 1'b0;
      // push-pull drive in output and alternate modes
      if (m == MODE_OUTPUT)
      begin
        st_nxt.out[p]  = st_r.lvl[p];
        st_nxt.oe_n[p] = 1'b0;
        st_nxt.rd[p]   = st_r.lvl[p];
      end
      else if (m == MODE_ALT)
      begin
        st_nxt.out[p]  = alt_lvl;
        st_nxt.oe_n[p] = 1'b0;
        st_nxt.rd[p]   = alt_lvl;
      end
      else
      begin
        st_nxt.out[p]  = 1'b0;
        st_nxt.oe_n[p] = 1'b1;
        // input read is the synchronised pad
        st_nxt.rd[p]   = st_r.sync2[p];
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // all pads input with drivers off after reset
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r       <= '0;
      st_r.oe_n  <= '1;
    end
    else
      st_r <= st_nxt;
  end

  assign pad_out  = st_r.out;
  assign pad_oe_n = st_r.oe_n;
  assign rd_level = st_r.rd;
  assign rd_mode  = st_r.mode;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // alarm sets on fire
  a_alarm_rise: assert property (@(posedge mclk) disable iff (sys_rst)
    alarm_fire |=> st_r.alarm)
    else $error("alarm did not rise on fire");

  a_alarm_fall: assert property (@(posedge mclk) disable iff (sys_rst)
    (alarm_clear && !alarm_fire) |=> !st_r.alarm)
    else $error("alarm did not fall on clear");

  a_alarm_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (!alarm_fire && !alarm_clear) |=> $stable(st_r.alarm))
    else $error("alarm changed while idle");

  a_plain_alt: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r.mode[1:0] != MODE_ALT)
    else $error("pad zero took alternate mode");

  a_plain_one: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r.mode[3:2] != MODE_ALT)
    else $error("pad one took alternate mode");

  a_plain_two: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r.mode[5:4] != MODE_ALT)
    else $error("pad two took alternate mode");

  a_plain_three: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r.mode[7:6] != MODE_ALT)
    else $error("pad three took alternate mode");

  a_plain_four: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r.mode[9:8] != MODE_ALT)
    else $error("pad four took alternate mode");

  a_mode_legal: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[1:0] != 2'h3) && (st_r.mode[15:14] != 2'h3))
    else $error("illegal mode stored");

  a_mode_write: assert property (@(posedge mclk) disable iff (sys_rst)
    (cfg_we && cfg_pad == 3'h1 && cfg_mode == MODE_OUTPUT) |=> (rd_mode[3:2] == MODE_OUTPUT))
    else $error("mode write lost");

  a_mode_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    !cfg_we |=> $stable(st_r.mode))
    else $error("mode changed without write");

  a_input_undriven: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[1:0] == MODE_INPUT) |=> pad_oe_n[0])
    else $error("input pad driven");

  a_input_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[15:14] == MODE_INPUT) |=> (pad_out[7] == 1'b0 && pad_oe_n[7]))
    else $error("input pad seven driven");

  a_output_level: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[1:0] == MODE_OUTPUT && $stable(st_r.mode[1:0])) |=>
      (pad_out[0] == $past(st_r.lvl[0]) && !pad_oe_n[0]))
    else $error("output pad level wrong");

  a_lvl_write: assert property (@(posedge mclk) disable iff (sys_rst)
    (lvl_we && lvl_pad == 3'h1 && st_r.mode[3:2] == MODE_OUTPUT) |=>
      (st_r.lvl[1] == $past(lvl_val)))
    else $error("level write lost");

  a_rd_output: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[3:2] == MODE_OUTPUT) |=> (rd_level[1] == $past(st_r.lvl[1])))
    else $error("output read back wrong");

  a_push_pull: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[3:2] == MODE_OUTPUT) |=> !pad_oe_n[1])
    else $error("output pad not driven");

  a_lvl_refused: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[11:10] != MODE_OUTPUT) |=> $stable(st_r.lvl[5]))
    else $error("level stored outside output mode");

  a_alarm_pad: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[13:12] == MODE_ALT) |=> (pad_out[6] == $past(st_r.alarm)))
    else $error("alarm pad wrong");

  a_alarm_drive: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[13:12] == MODE_ALT) |=> !pad_oe_n[6])
    else $error("alarm pad not driven");

  a_tx_pad: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[11:10] == MODE_ALT) |=> (pad_out[5] == $past(radio_transmit_monitor)))
    else $error("transmit monitor pad wrong");

  a_tx_read: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[11:10] == MODE_ALT) |=> (rd_level[5] == $past(radio_transmit_monitor)))
    else $error("transmit monitor read wrong");

  a_buzz_pad: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[15:14] == MODE_ALT) |=> (pad_out[7] == $past(st_r.buzz) && !pad_oe_n[7]))
    else $error("buzzer pad wrong");

  a_input_read: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_r.mode[1:0] == MODE_INPUT) |=> (rd_level[0] == $past(st_r.sync2[0])))
    else $error("input read wrong");

  a_sync_chain: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r.sync2 == $past(st_r.sync1))
    else $error("synchroniser chain broken");

  a_buzz_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    !tone_on |=> !st_r.buzz)
    else $error("buzzer runs with tone off");

  a_buzz_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    (tone_on && tone_half != '0 && st_r.cnt < tone_half - 16'h0001) |=> $stable(st_r.buzz))
    else $error("buzzer toggled early");

  a_buzz_edge: assert property (@(posedge mclk) disable iff (sys_rst)
    (tone_on && tone_half != '0 && st_r.cnt >= tone_half - 16'h0001) |=>
      (st_r.buzz != $past(st_r.buzz)))
    else $error("buzzer missed toggle");

endmodule

// file: tb/pad_partner.sv
/*
  far side model: external devices and host on the pads.
  assumes pad_oe_n low means the block drives the wire.
*/
`timescale 1ns/1ps
module pad_partner
  import pad_port_pkg::*;
(
  // clock
  input  wire logic                mclk,
  // block side and external drivers
  input  wire logic [NUM_PADS-1:0] pad_out,
  input  wire logic [NUM_PADS-1:0] pad_oe_n,
  input  wire logic [NUM_PADS-1:0] ext_val,
  input  wire logic [NUM_PADS-1:0] ext_en,
  output logic      [NUM_PADS-1:0] pad_in,
  // host wake state
  output logic                     host_awake
);
  logic [NUM_PADS-1:0] float_r = '0;
  logic                awake_r = 1'b0;
  // host powers up on alarm rise
  always_ff @(posedge mclk)
    if (!pad_oe_n[PAD_SIX] && pad_out[PAD_SIX])
      awake_r <= 1'b1;
  assign host_awake = awake_r;
  // no pull on the wire, so a floating pad wanders
  always_ff @(posedge mclk)
    float_r <= ~float_r;
  always_comb
    for (int i = 0; i < NUM_PADS; i++)
      pad_in[i] = !pad_oe_n[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : float_r[i]);
endmodule

// file: tb/general_purpose_pad_port_tb.sv
/*
  self-checking bench for the pad port.
  assumes the partner model resolves every pad wire.
*/
`timescale 1ns/1ps
module general_purpose_pad_port_tb;
  import pad_port_pkg::*;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
  logic mclk = 0, sys_rst = 1, cfg_we = 0, lvl_we = 0, lvl_val = 0;
  logic radio_transmit_monitor = 0, alarm_fire = 0, alarm_clear = 0, tone_on = 0;
  logic [2:0] cfg_pad = 0, lvl_pad = 0;
  logic [1:0] cfg_mode = 0;
  logic [TONE_W-1:0] tone_half = 16'h0003;
  logic [7:0] pad_in, pad_out, pad_oe_n, rd_level, ext_val = 0, ext_en = 0, t;
  logic [15:0] rd_mode;
  logic host_awake;
  int fails = 0, comparisons = 0;
  general_purpose_pad_port general_purpose_pad_port_i (.mclk(mclk), .sys_rst(sys_rst),
    .cfg_we(cfg_we), .cfg_pad(cfg_pad), .cfg_mode(cfg_mode), .lvl_we(lvl_we),
    .lvl_pad(lvl_pad), .lvl_val(lvl_val), .radio_transmit_monitor(radio_transmit_monitor),
    .alarm_fire(alarm_fire), .alarm_clear(alarm_clear), .tone_on(tone_on),
    .tone_half(tone_half), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .rd_level(rd_level), .rd_mode(rd_mode));
  pad_partner pad_partner_i (.mclk(mclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in), .host_awake(host_awake));
  initial
    forever #20 mclk = ~mclk;
  // settle a few cycles, judge between edges
  task automatic w(int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic cfg(logic [2:0] p, logic [1:0] m);
    @(posedge mclk);
    cfg_we <= 1; cfg_pad <= p; cfg_mode <= m;
    @(posedge mclk);
    cfg_we <= 0;
    w(3);
  endtask
  task automatic lvl(logic [2:0] p, logic v);
    @(posedge mclk);
    lvl_we <= 1; lvl_pad <= p; lvl_val <= v;
    @(posedge mclk);
    lvl_we <= 0;
    w(3);
  endtask
  task automatic pulse(logic f, logic c);
    @(posedge mclk);
    alarm_fire <= f; alarm_clear <= c;
    @(posedge mclk);
    alarm_fire <= 0; alarm_clear <= 0;
    w(3);
  endtask
  task automatic t_modes;
    cfg(3, 2'h3);
    `CHK(rd_mode[7:6], MODE_INPUT)
    cfg(2, MODE_ALT);
    `CHK({rd_mode[5:4], pad_oe_n[2]}, 3'h1)
    @(posedge mclk); ext_en[0] <= 1; ext_val[0] <= 1; w(4);
    `CHK(rd_level[0], 1'h1)
    @(posedge mclk); ext_val[0] <= 0; w(4);
    `CHK(rd_level[0], 1'h0)
  endtask
  task automatic t_output;
    lvl(4, 1); cfg(4, MODE_OUTPUT); cfg(1, MODE_OUTPUT);
    `CHK(pad_out[4], 1'h0)
    lvl(1, 1);
    `CHK({pad_out[1], pad_oe_n[1], rd_level[1]}, 3'h5)
    lvl(1, 0);
    `CHK({pad_out[1], pad_oe_n[1], rd_level[1]}, 3'h0)
  endtask
  task automatic t_alt;
    cfg(5, MODE_ALT); @(posedge mclk); radio_transmit_monitor <= 1; w(3);
    `CHK({pad_out[5], pad_oe_n[5], rd_mode[11:10]}, 4'hA)
    lvl(5, 0);
    `CHK(pad_out[5], 1'h1)
    @(posedge mclk); radio_transmit_monitor <= 0; w(3);
    `CHK(pad_out[5], 1'h0)
    cfg(6, MODE_ALT); pulse(1, 0); w(8);
    `CHK({pad_out[6], pad_oe_n[6]}, 2'h2)
    `CHK(host_awake, 1'h1)
    pulse(0, 1);
    `CHK(pad_out[6], 1'h0)
    pulse(1, 1);
    `CHK(pad_out[6], 1'h1)
  endtask
  task automatic t_buzz;
    cfg(7, MODE_ALT); @(posedge mclk); tone_on <= 1; w(1);
    t = pad_out;
    repeat (10) if (pad_out[7] === t[7]) @(negedge mclk);
    t = pad_out;
    repeat (2) begin @(negedge mclk); `CHK(pad_out[7], t[7]) end
    @(negedge mclk); `CHK(pad_out[7], ~t[7])
    @(posedge mclk); tone_on <= 0; w(3);
    `CHK(pad_out[7], 1'h0)
  endtask
  task automatic conclude;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    sys_rst <= 0; w(1);
    `CHK({rd_mode, pad_oe_n, pad_out, rd_level}, 40'h0000FF0000)
    `CHK(host_awake, 1'h0)
    t_modes(); t_output(); t_alt(); t_buzz();
    conclude();
  end
  // whole run is just over a hundred cycles
  initial
  begin
    #100us;
    fails++;
    conclude();
  end
endmodule
